// File: logic/sfs_pkg.sv
// sfs_pkg: register map, field positions, reset values and frame timing
// figures shared by the frame sync timing block.
// assumes an 8-bit register address space and 8-bit register data.
package sfs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] ADDR_COMMON_H   = 8'h12;
    localparam logic [7:0] ADDR_VWIN_START = 8'h19;
    localparam logic [7:0] ADDR_VWIN_END   = 8'h1A;
    localparam logic [7:0] ADDR_LI_HS_HIGH = 8'h2A;
    localparam logic [7:0] ADDR_LI_ADJ_LOW = 8'h2B;
    localparam logic [7:0] ADDR_VS_EXT_LOW = 8'h2D;
    localparam logic [7:0] ADDR_VS_EXT_HI  = 8'h2E;
    localparam logic [7:0] ADDR_LUMA_AVG   = 8'h2F;
    localparam logic [7:0] ADDR_BLANK_WIN  = 8'h32;

    // reset values
    localparam logic [7:0] RST_COMMON_H   = 8'h20;
    localparam logic [7:0] RST_VWIN_START = 8'h01;
    localparam logic [7:0] RST_VWIN_END   = 8'h97;
    localparam logic [7:0] RST_ZERO       = 8'h00;

    // field positions
    localparam int LI_EN_BIT      = 7;
    localparam int LI_MSB_HI      = 6;
    localparam int LI_MSB_LO      = 5;
    localparam int LI_RSVD_BIT    = 4;
    localparam int HS_END_HI      = 3;
    localparam int HS_END_LO      = 2;
    localparam int HS_START_HI    = 1;
    localparam int HS_START_LO    = 0;
    localparam int CH_HALF_RES    = 6;
    localparam int CH_AVG_EN      = 5;
    localparam int BW_PAD_WIDE    = 7;
    localparam int BW_PAD_NARROW  = 6;
    localparam int BW_VERTICAL_WINDOW_END_LSB    = 5;
    localparam int BW_VSTART_LSB  = 4;
    localparam int BW_HWIN_A_HI   = 3;
    localparam int BW_HWIN_A_LO   = 2;
    localparam int BW_HWIN_B_HI   = 1;
    localparam int BW_HWIN_B_LO   = 0;

    ////////////////////////////////////////////////////////////////////////
    // frame timing, in pixel clocks and line periods
    localparam logic [11:0] ACT_PIX_FULL   = 12'h640;
    localparam logic [11:0] ACT_PIX_HALF   = 12'h320;
    localparam logic [11:0] HBLANK_BASE    = 12'h100;
    localparam logic [11:0] PAD_WIDE       = 12'h040;
    localparam logic [11:0] PAD_NARROW     = 12'h010;
    localparam logic [11:0] PAD_NONE       = 12'h000;
    localparam logic [10:0] FRAME_LN_FULL  = 11'h3CE;
    localparam logic [10:0] FRAME_LN_HALF  = 11'h1E7;
    localparam logic [16:0] VS_BASE_LINES  = 17'h00004;
    localparam logic [7:0]  HS_START_LOW   = 8'h00;
    localparam logic [7:0]  HS_END_LOW     = 8'h40;
    localparam int          VWIN_SH_FULL   = 2;
    localparam int          VWIN_SH_HALF   = 1;

    // sync strobes toward the host receiver
    typedef struct packed {
        logic vsync;
        logic hsync;
        logic href;
    } sfs_sync_t;

    // one register port access
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } sfs_req_t;

endpackage

// File: logic/sfs_frame_timing.sv
// sfs_frame_timing: configuration registers and line/frame sync generator
// of the sensor video output, with the average luminance readout.
// assumes the register master drives one-cycle strobes synchronous to
// ref_clk and the channel averages are stable between frame ends.
//
// Behaviour
// RQ1 - line interval stretch applies only when enabled; 10-bit value from two registers
// RQ2 - each adjust unit adds one 1/974 frame (full) or 1/487 (half)
// RQ3 - control-L bits 3:2 are hsync end point high bits
// RQ4 - control-L bits 1:0 are hsync start point high bits
// RQ5 - vsync lasts four lines, plus one line per low extension count
// RQ6 - each high extension count adds 256 lines to vsync
// RQ7 - luminance register updates automatically only while average enable is set
// RQ8 - luminance is sum of four channel averages divided by four
// RQ9 - control-M bit 7 adds 040 blank pixels each side of href
// RQ10 - control-M bit 6 adds 010 blank pixels each side of href
// RQ11 - with neither option set no extra blank pixels appear
// RQ12 - control-M bit 5 is vertical window end low bit
// RQ13 - control-M bit 4 is vertical window start low bit
// RQ14 - control-M bits 3:2 and 1:0 are horizontal window low bits
// RQ15 - average counter runs only while its enable bit is one
// RQ16 - vertical window step is four lines full, two lines half resolution
// RQ17 - vsync width is four lines plus the 16-bit extension value
`timescale 1ns/1ps

module sfs_frame_timing (
    input  wire logic             ref_clk,
    input  wire logic             srst,
    input  wire sfs_pkg::sfs_req_t reg_req,
    output logic [7:0]            reg_rdata,
    input  wire logic [7:0]       blue_avg,
    input  wire logic [7:0]       green_b_avg,
    input  wire logic [7:0]       green_r_avg,
    input  wire logic [7:0]       red_avg,
    output sfs_pkg::sfs_sync_t    sync_out,
    output logic [1:0]            hwin_start_low,
    output logic [1:0]            hwin_end_low
);

    ////////////////////////////////////////////////////////////////////////
    // register storage
    logic [7:0]  common_h_q;
    logic [7:0]  vwin_start_q;
    logic [7:0]  vwin_end_q;
    logic [7:0]  li_hs_high_q;
    logic [7:0]  li_adj_low_q;
    logic [7:0]  vs_ext_low_q;
    logic [7:0]  vs_ext_high_q;
    logic [7:0]  luma_q;
    logic [7:0]  blank_win_q;
    logic [7:0]  rdata_q;

    // timing state
    logic [11:0] pix_q;
    logic [10:0] line_q;
    logic [16:0] vs_cnt_q;
    sfs_pkg::sfs_sync_t sync_q;
    sfs_pkg::sfs_sync_t sync_d;

    // derived configuration
    logic        half_res;
    logic [11:0] act_pix;
    logic [11:0] pad;
    logic [11:0] line_len;
    logic [9:0]  li_adj;
    logic [10:0] frame_lines;
    logic        line_end;
    logic        frame_end;
    logic [8:0]  vstart9;
    logic [8:0]  vend9;
    logic [10:0] vstart_ln;
    logic [10:0] vertical_window_end_ln;
    logic [9:0]  hs_start;
    logic [9:0]  hs_end;
    logic [9:0]  luma_sum;
    logic        avg_on;
    logic        wr_en;
    logic        in_vwin;
    logic        in_active;
    logic        in_hsync;

    assign wr_en = reg_req.wr;

    ////////////////////////////////////////////////////////////////////////
    // register writes, one process per group of related registers;
    // unmapped offsets are dropped so software probing the gaps is harmless

    // resolution, average enable and vertical window bounds
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            common_h_q   <= sfs_pkg::RST_COMMON_H;
            vwin_start_q <= sfs_pkg::RST_VWIN_START;
            vwin_end_q   <= sfs_pkg::RST_VWIN_END;
        end else if (wr_en) begin
            case (reg_req.addr)
                sfs_pkg::ADDR_COMMON_H:   common_h_q   <= reg_req.wdata;
                sfs_pkg::ADDR_VWIN_START: vwin_start_q <= reg_req.wdata;
                sfs_pkg::ADDR_VWIN_END:   vwin_end_q   <= reg_req.wdata;
                default: ;
            endcase
        end
    end

    // line interval stretch and hsync edge high bits
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            li_hs_high_q <= sfs_pkg::RST_ZERO;
            li_adj_low_q <= sfs_pkg::RST_ZERO;
        end else if (wr_en) begin
            case (reg_req.addr)
                sfs_pkg::ADDR_LI_HS_HIGH: li_hs_high_q <= reg_req.wdata;
                sfs_pkg::ADDR_LI_ADJ_LOW: li_adj_low_q <= reg_req.wdata;
                default: ;
            endcase
        end
    end

    // vsync width extension; the counter takes it at the next frame start
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            vs_ext_low_q  <= sfs_pkg::RST_ZERO;
            vs_ext_high_q <= sfs_pkg::RST_ZERO;
        end else if (wr_en) begin
            case (reg_req.addr)
                sfs_pkg::ADDR_VS_EXT_LOW: vs_ext_low_q  <= reg_req.wdata;
                sfs_pkg::ADDR_VS_EXT_HI:  vs_ext_high_q <= reg_req.wdata;
                default: ;
            endcase
        end
    end

    // blanking pad select and window low bits
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            blank_win_q <= sfs_pkg::RST_ZERO;
        end else if (wr_en && reg_req.addr == sfs_pkg::ADDR_BLANK_WIN) begin
            blank_win_q <= reg_req.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // luminance average: hardware update at frame end wins over a write
    // in the same cycle, so a fresh measurement is never lost;
    // while average enable is set the readout is at most one frame old, so software wanting a fresh
    // value waits for the next vsync before reading it
    // the sum keeps two spare bits so four full-scale averages cannot wrap
    assign avg_on   = common_h_q[sfs_pkg::CH_AVG_EN];
    assign luma_sum = {2'h0, blue_avg} + {2'h0, green_b_avg}
                    + {2'h0, green_r_avg} + {2'h0, red_avg};      // [RQ8]

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            luma_q <= sfs_pkg::RST_ZERO;
        end else if (frame_end && avg_on) begin                 // [RQ7] [RQ15]
            luma_q <= luma_sum[9:2];                             // [RQ8]
        end else if (wr_en && reg_req.addr == sfs_pkg::ADDR_LUMA_AVG) begin
            luma_q <= reg_req.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data, one cycle after the strobe; unmapped reads return zero
    // a register written in the cycle before a read is seen with its new value
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rdata_q <= sfs_pkg::RST_ZERO;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                sfs_pkg::ADDR_COMMON_H:   rdata_q <= common_h_q;
                sfs_pkg::ADDR_VWIN_START: rdata_q <= vwin_start_q;
                sfs_pkg::ADDR_VWIN_END:   rdata_q <= vwin_end_q;
                sfs_pkg::ADDR_LI_HS_HIGH: begin
                    rdata_q <= li_hs_high_q;
                    rdata_q[sfs_pkg::LI_RSVD_BIT] <= 1'b0;       // reserved reads zero
                end
                sfs_pkg::ADDR_LI_ADJ_LOW: rdata_q <= li_adj_low_q;
                sfs_pkg::ADDR_VS_EXT_LOW: rdata_q <= vs_ext_low_q;
                sfs_pkg::ADDR_VS_EXT_HI:  rdata_q <= vs_ext_high_q;
                sfs_pkg::ADDR_LUMA_AVG:   rdata_q <= luma_q;
                sfs_pkg::ADDR_BLANK_WIN:  rdata_q <= blank_win_q;
                default:                  rdata_q <= sfs_pkg::RST_ZERO;
            endcase
        end
    end

    assign reg_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // line geometry: active width plus blank pad on both sides of href
    // the pad lands on both sides, so each option costs twice its count
    // in line length and slows the frame rate accordingly
    assign half_res = common_h_q[sfs_pkg::CH_HALF_RES];
    assign act_pix  = half_res ? sfs_pkg::ACT_PIX_HALF : sfs_pkg::ACT_PIX_FULL;

    // both options set: the wide pad wins
    always_comb begin
        if (blank_win_q[sfs_pkg::BW_PAD_WIDE]) begin
            pad = sfs_pkg::PAD_WIDE;                             // [RQ9]
        end else if (blank_win_q[sfs_pkg::BW_PAD_NARROW]) begin
            pad = sfs_pkg::PAD_NARROW;                           // [RQ10]
        end else begin
            pad = sfs_pkg::PAD_NONE;                             // [RQ11]
        end
    end

    assign line_len = act_pix + pad + pad + sfs_pkg::HBLANK_BASE;

    // frame length: one extra line per adjust unit, i.e. 1/974 of a full
    // frame or 1/487 of a half frame, only while stretching is enabled
    assign li_adj = {li_hs_high_q[sfs_pkg::LI_MSB_HI:sfs_pkg::LI_MSB_LO],
                     li_adj_low_q};                              // [RQ1]
    assign frame_lines = (half_res ? sfs_pkg::FRAME_LN_HALF
                                   : sfs_pkg::FRAME_LN_FULL)     // [RQ2]
                       + (li_hs_high_q[sfs_pkg::LI_EN_BIT]
                          ? {1'b0, li_adj} : 11'h000);           // [RQ1]

    // greater-or-equal compares keep the counters sane if software shrinks
    // the line or frame while the counters sit beyond the new end
    assign line_end  = (pix_q >= line_len - 12'h001);
    assign frame_end = line_end && (line_q >= frame_lines - 11'h001);

    ////////////////////////////////////////////////////////////////////////
    // pixel and line counters
    // both restart together at frame end, so every frame's first line
    // begins at pixel zero whatever was written mid-frame
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pix_q <= 12'h000;
        end else if (line_end) begin
            pix_q <= 12'h000;
        end else begin
            pix_q <= pix_q + 12'h001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            line_q <= 11'h000;
        end else if (frame_end) begin
            line_q <= 11'h000;
        end else if (line_end) begin
            line_q <= line_q + 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // vsync width counter: loaded at frame start, counts down per line
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            vs_cnt_q <= sfs_pkg::VS_BASE_LINES;
        end else if (frame_end) begin
            vs_cnt_q <= sfs_pkg::VS_BASE_LINES                   // [RQ5] [RQ17]
                      + {1'b0, vs_ext_high_q, vs_ext_low_q};     // [RQ6]
        end else if (line_end && vs_cnt_q != 17'h00000) begin
            vs_cnt_q <= vs_cnt_q - 17'h00001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // vertical window in lines: 9-bit value scaled by 4 or 2 lines per step
    // a start at or past the end gives no active lines at all
    assign vstart9 = {vwin_start_q, blank_win_q[sfs_pkg::BW_VSTART_LSB]}; // [RQ13]
    assign vend9   = {vwin_end_q, blank_win_q[sfs_pkg::BW_VERTICAL_WINDOW_END_LSB]};     // [RQ12]
    assign vstart_ln = half_res ? ({2'h0, vstart9} << sfs_pkg::VWIN_SH_HALF)
                                : ({2'h0, vstart9} << sfs_pkg::VWIN_SH_FULL); // [RQ16]
    assign vertical_window_end_ln   = half_res ? ({2'h0, vend9} << sfs_pkg::VWIN_SH_HALF)
                                : ({2'h0, vend9} << sfs_pkg::VWIN_SH_FULL);   // [RQ16]

    // hsync edges: high two bits from software, low eight fixed
    assign hs_start = {li_hs_high_q[sfs_pkg::HS_START_HI:sfs_pkg::HS_START_LO],
                       sfs_pkg::HS_START_LOW};                   // [RQ4]
    assign hs_end   = {li_hs_high_q[sfs_pkg::HS_END_HI:sfs_pkg::HS_END_LO],
                       sfs_pkg::HS_END_LOW};                     // [RQ3]

    ////////////////////////////////////////////////////////////////////////
    // window tests, kept apart so each compare is easy to follow
    assign in_vwin   = (line_q >= vstart_ln) && (line_q < vertical_window_end_ln);   // [RQ12] [RQ13]
    assign in_active = (pix_q >= pad) && (pix_q < pad + act_pix);    // [RQ9] [RQ10] [RQ11]
    // an end at or before the start leaves hsync low for the whole line
    assign in_hsync  = (pix_q >= {2'h0, hs_start}) && (pix_q < {2'h0, hs_end});

    // sync strobes, registered so the host sees clean edges
    always_comb begin
        sync_d.href  = in_vwin && in_active;
        sync_d.hsync = in_hsync;
        sync_d.vsync = (vs_cnt_q != 17'h00000);                  // [RQ5] [RQ6]
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sync_q <= '0;
        end else begin
            sync_q <= sync_d;
        end
    end

    assign sync_out = sync_q;

    // horizontal window low bits are handed on to the window logic as-is
    assign hwin_start_low = blank_win_q[sfs_pkg::BW_HWIN_A_HI:sfs_pkg::BW_HWIN_A_LO]; // [RQ14]
    assign hwin_end_low   = blank_win_q[sfs_pkg::BW_HWIN_B_HI:sfs_pkg::BW_HWIN_B_LO]; // [RQ14]

endmodule

// File: verif/sfs_frame_timing_asserts.sv
// sfs_frame_timing_chk: port-level assertions for the frame sync timing block.
// assumes it is bound to sfs_frame_timing and sees only that module's ports.
`timescale 1ns/1ps

module sfs_frame_timing_chk (
    input wire logic               ref_clk,
    input wire logic               srst,
    input wire sfs_pkg::sfs_req_t  reg_req,
    input wire logic [7:0]         reg_rdata,
    input wire sfs_pkg::sfs_sync_t sync_out,
    input wire logic [1:0]         hwin_start_low,
    input wire logic [1:0]         hwin_end_low
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    ////////////////////////////////////////////////////////////////////////
    logic [7:0] ext_lo_q;
    int         vs_cnt_q;

    // shadow of the low vsync extension so a read can be judged
    always_ff @(posedge ref_clk) begin
        if (srst) ext_lo_q <= 8'h00;
        else if (reg_req.wr && reg_req.addr == 8'h2D) ext_lo_q <= reg_req.wdata;
    end

    // vsync high time; too long a pulse for a repetition, so it is counted
    always_ff @(posedge ref_clk) begin
        if (srst || !sync_out.vsync) vs_cnt_q <= 0;
        else vs_cnt_q <= vs_cnt_q + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    a_rdata_hold_idle: assert property (!$past(reg_req.rd) |-> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (reg_req.rd && reg_req.addr inside {8'h2C, 8'h30, 8'h31}
        |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_reserved_bit_low: assert property (reg_req.rd && reg_req.addr == 8'h2A |=> !reg_rdata[4])
        else $error("reserved bit reads one");
    a_vsext_readback: assert property (reg_req.rd && reg_req.addr == 8'h2D
        |=> reg_rdata == $past(ext_lo_q))
        else $error("low vsync extension readback wrong");
    a_hwin_follow: assert property (reg_req.wr && reg_req.addr == 8'h32 |=>
        hwin_start_low == $past(reg_req.wdata[3:2]) && hwin_end_low == $past(reg_req.wdata[1:0]))
        else $error("window low bits not taken");
    a_vsync_after_reset: assert property ($fell(srst) |-> ##[1:2] sync_out.vsync)
        else $error("vsync missing after reset");
    a_vsync_min_width: assert property ($fell(sync_out.vsync) && !$past(srst)
        |-> vs_cnt_q >= 4224)
        else $error("vsync shorter than four lines");
    a_href_min_run: assert property ($rose(sync_out.href) |-> sync_out.href[*8])
        else $error("href pulse too short");

    c_href_seen: cover property ($rose(sync_out.href));
    c_vsync_end: cover property ($fell(sync_out.vsync));
    c_ext_read: cover property (reg_req.rd && reg_req.addr == 8'h2D);
    c_blank_wr: cover property (reg_req.wr && reg_req.addr == 8'h32);
endmodule

// File: verif/sfs_host_rx.sv
// sfs_host_rx: receiver model measuring sync pulse widths and line period.
// assumes sync levels are registered on ref_clk and active high.
`timescale 1ns/1ps

module sfs_host_rx (
    input  wire logic               ref_clk,
    input  wire logic               srst,
    input  wire sfs_pkg::sfs_sync_t sync_in,
    output int                      vs_len,
    output int                      hs_w,
    output int                      hr_w,
    output int                      hr_per,
    output int                      lines
);
    int vs_c, hs_c, hr_c, per_c;

    ////////////////////////////////////////////////////////////////////////
    // widths are latched at the falling side, period at each href rise
    always @(posedge ref_clk) begin
        if (srst) begin
            {vs_c, hs_c, hr_c, per_c, vs_len, hs_w, hr_w, hr_per, lines} = '0;
        end else begin
            per_c++;
            if (sync_in.href && hr_c == 0) begin
                hr_per = per_c;
                per_c = 0;
                lines++;
            end
            if (sync_in.vsync) vs_c++;
            else if (vs_c != 0) {vs_len, vs_c} = {vs_c, 32'd0};
            if (sync_in.hsync) hs_c++;
            else if (hs_c != 0) {hs_w, hs_c} = {hs_c, 32'd0};
            if (sync_in.href) hr_c++;
            else if (hr_c != 0) {hr_w, hr_c} = {hr_c, 32'd0};
        end
    end
endmodule

// File: verif/tb.sv
// tb: self-checking bench for sfs_frame_timing with a receiver model.
// assumes half resolution is selected inside the first line; no frame end
// falls inside the run, so only the first vsync pulse is seen.
`timescale 1ns/1ps

module tb;
    logic               ref_clk = 1'b0;
    logic               srst = 1'b1;
    sfs_pkg::sfs_req_t  req = '0;
    logic [7:0]         rdata;
    logic [31:0]        avg_q = '0;
    sfs_pkg::sfs_sync_t sync;
    logic [1:0]         hws, hwe;
    logic [7:0]         mdl [0:255];
    logic [7:0]         v, w, a;
    int                 errors = 0, checks_done = 0, seed = 56421;
    int                 vs_len, hs_w, hr_w, hr_per, lines, pad, s, e;

    always #50 ref_clk = ~ref_clk;

    // channel averages wander; frame end is beyond this run
    always @(posedge ref_clk) avg_q <= $random(seed);

    sfs_frame_timing u_dut (.ref_clk(ref_clk), .srst(srst), .reg_req(req), .reg_rdata(rdata),
        .blue_avg(avg_q[7:0]), .green_b_avg(avg_q[15:8]), .green_r_avg(avg_q[23:16]),
        .red_avg(avg_q[31:24]), .sync_out(sync), .hwin_start_low(hws), .hwin_end_low(hwe));
    sfs_host_rx u_rx (.ref_clk(ref_clk), .srst(srst), .sync_in(sync), .vs_len(vs_len),
        .hs_w(hs_w), .hr_w(hr_w), .hr_per(hr_per), .lines(lines));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge ref_clk);
        req <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        req.wr <= 1'b0;
        mdl[ad] = d;
    endtask

    // read data appear in the cycle after the strobe and hold until the next read
    task automatic rd(input logic [7:0] ad);
        logic [7:0] x;
        @(posedge ref_clk);
        req <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        req.rd <= 1'b0;
        @(negedge ref_clk);
        x = ad inside {8'h12, 8'h19, 8'h1A, 8'h2A, 8'h2B, 8'h2D, 8'h2E, 8'h2F, 8'h32} ? mdl[ad] : 8'h00;
        if (ad == 8'h2A) x[4] = 1'b0;
        check(32'(rdata), 32'(x), "reg_rdata");
    endtask

    task automatic wait_lines(input int k);
        int t0;
        t0 = lines;
        // two spare lines cover a window start moved later by new settings
        for (int n = 0; n < 1300 * (k + 2) && lines < t0 + k; n++) @(posedge ref_clk);
        check(32'(lines >= t0 + k), 32'h1, "href lines");
    endtask

    task automatic read_all();
        logic [7:0] map [11] = '{8'h12, 8'h19, 8'h1A, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h2E,
            8'h2F, 8'h30, 8'h32};
        foreach (map[i]) rd(map[i]);
    endtask

    task automatic close_out();
        if (errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // hang guard, about twice the expected run
    initial begin
        repeat (60000) @(posedge ref_clk);
        errors++;
        close_out();
    end

    initial begin
        for (int i = 0; i < 256; i++) mdl[i] = 8'h00;
        mdl[8'h12] = sfs_pkg::RST_COMMON_H;
        mdl[8'h19] = sfs_pkg::RST_VWIN_START;
        mdl[8'h1A] = sfs_pkg::RST_VWIN_END;
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        read_all();
        // half resolution early, inside line 0, so lines are 1056 clocks
        wr(8'h12, 8'h60);
        foreach (a[i]) wr(8'h2B + 8'(i % 5), 8'($random(seed)));
        wr(8'h2E, 8'h00);
        wr(8'h2D, 8'h02);
        read_all();
        for (int n = 0; n < 9000 && vs_len == 0; n++) @(posedge ref_clk);
        // the extension written above is taken at the next frame start only,
        // so the first pulse after reset is the plain four lines
        check(32'(vs_len), 32'h00001080, "vsync width");
        // window start of 2 steps of 2 lines: href rises as vsync falls,
        // two clocks beyond the pulse width counted from release
        check(32'(hr_per), 32'h00001082, "first href offset");
        for (int i = 0; i < 8; i++) begin
            v = 8'($random(seed));
            s = int'(v[1:0]);
            e = int'(v[3:2]) < s ? s : int'(v[3:2]);
            a = {v[7:4], 2'(e), 2'(s)};
            w = {2'(i), 6'($random(seed))};
            pad = w[7] ? 64 : (w[6] ? 16 : 0);
            wr(8'h32, w);
            wr(8'h2A, a);
            wait_lines(3);
            check(32'(hr_per), 32'(800 + 2 * pad + 256), "line period");
            check(32'(hr_w), 32'd800, "href width");
            check(32'(hs_w), 32'((e - s) * 256 + 64), "hsync width");
            check({28'h0, hws, hwe}, {28'h0, w[3:0]}, "window low bits");
            rd(8'h2A);
            rd(8'h32);
        end
        close_out();
    end
endmodule

bind sfs_frame_timing sfs_frame_timing_chk u_chk (.ref_clk(ref_clk), .srst(srst),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .sync_out(sync_out),
    .hwin_start_low(hwin_start_low), .hwin_end_low(hwin_end_low));
